// ==== dpt_timing_map.vh ====
`ifndef DPT_TIMING_MAP_VH
`define DPT_TIMING_MAP_VH

// ----------------------------------------
// clock and pin field layout
// ----------------------------------------
`define DPT_CLK_NS 40
`define DPT_PIN_W 16
`define DPT_PIN_CK 15
`define DPT_PIN_CKE 14
`define DPT_PIN_CSN 13
`define DPT_PIN_PAR 12
`define DPT_PIN_CMD_HI 11
`define DPT_PIN_CMD_LO 8
`define DPT_PIN_ADDR_HI 7
`define DPT_PIN_ADDR_LO 0
`define DPT_CMD_W 4
`define DPT_ADDR_W 8

// ----------------------------------------
// command codes
// ----------------------------------------
`define DPT_CMD_DES 4'hf

// ----------------------------------------
// timing in device clock edges (nCK)
// ----------------------------------------
`define DPT_CPDED_NCK 3'h4
`define DPT_PL_NCK 2'h1
`define DPT_PAR_ALERT_NCK 8'h40
`define DPT_CRC_ALERT_NCK 8'h08
`define DPT_CNT_ZERO 8'h00

// ----------------------------------------
// timing in nanoseconds and clk cycles
// ----------------------------------------
`define DPT_CRC_ON_MIN_NS 3
`define DPT_CRC_ON_MAX_NS 13
`define DPT_CRC_ON_MIN_CYC ((`DPT_CRC_ON_MIN_NS + `DPT_CLK_NS - 1) / `DPT_CLK_NS)
`define DPT_CRC_ON_MAX_RAW (`DPT_CRC_ON_MAX_NS / `DPT_CLK_NS)
`define DPT_CRC_ON_MAX_CYC ((`DPT_CRC_ON_MAX_RAW < 1) ? 1 : `DPT_CRC_ON_MAX_RAW)

`endif

// ==== dpt_cmd_timing.v ====
// Functional notes
// - device may decode commands up to 4 nCK after clock-enable falls
// - commands within parity latency of an errant command are not executed
// - alert asserts within parity latency plus 6 ns of parity error
// - parity alert held low between 56 and 128 nCK
// - write CRC mismatch drives alert within 3 to 13 ns
// - CRC alert held low between 6 and 10 nCK
`timescale 1ns/1ps
`default_nettype none
`include "dpt_timing_map.vh"

module dpt_cmd_timing (
    input wire clk,
    input wire rst,
    input wire ckPin,
    input wire ckePin,
    input wire csPinN,
    input wire [`DPT_CMD_W-1:0] cmdPin,
    input wire [`DPT_ADDR_W-1:0] addrPin,
    input wire parPin,
    input wire parEn,
    input wire parPersist,
    input wire parErrClr,
    input wire crcErrPulse,
    output reg cmdValid,
    output reg [`DPT_CMD_W-1:0] cmdCode,
    output reg [`DPT_ADDR_W-1:0] cmdAddr,
    output reg cmdPathOn,
    output reg parErrFlag,
    output reg alertN
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [`DPT_PIN_W-1:0] pinMeta_reg;
    reg [`DPT_PIN_W-1:0] pinSync_reg;
    reg ckPrev_reg;
    wire [`DPT_PIN_W-1:0] pinRaw;
    wire ckRise;
    wire ckeNow;
    wire csNowN;
    wire parNow;
    wire [`DPT_CMD_W-1:0] cmdNow;
    wire [`DPT_ADDR_W-1:0] addrNow;

    // every pin passes two flops; ck edges are found after the same
    // delay, so command fields and their edge stay aligned
    assign pinRaw = {ckPin, ckePin, csPinN, parPin, cmdPin, addrPin};

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pinMeta_reg <= {`DPT_PIN_W{1'b0}};
            pinSync_reg <= {`DPT_PIN_W{1'b0}};
            ckPrev_reg <= 1'b0;
        end else begin
            pinMeta_reg <= pinRaw;
            pinSync_reg <= pinMeta_reg;
            ckPrev_reg <= pinSync_reg[`DPT_PIN_CK];
        end
    end

    // one-cycle enable on each rising device clock edge
    assign ckRise = pinSync_reg[`DPT_PIN_CK] & ~ckPrev_reg;
    assign ckeNow = pinSync_reg[`DPT_PIN_CKE];
    assign csNowN = pinSync_reg[`DPT_PIN_CSN];
    assign parNow = pinSync_reg[`DPT_PIN_PAR];
    assign cmdNow = pinSync_reg[`DPT_PIN_CMD_HI:`DPT_PIN_CMD_LO];
    assign addrNow = pinSync_reg[`DPT_PIN_ADDR_HI:`DPT_PIN_ADDR_LO];

    // ----------------------------------------
    // command path disable on clock-enable low
    // ----------------------------------------
    reg [2:0] pdCnt_reg;
    // counter stops once the path is off, so it cannot wrap

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pdCnt_reg <= 3'h0;
            cmdPathOn <= 1'b1;
        end else if (ckRise) begin
            if (ckeNow) begin
                pdCnt_reg <= 3'h0;
                cmdPathOn <= 1'b1;
            end else if (cmdPathOn) begin
                // decoding goes on until the fourth low edge
                if (pdCnt_reg == `DPT_CPDED_NCK - 3'h1) begin
                    cmdPathOn <= 1'b0;
                end
                pdCnt_reg <= pdCnt_reg + 3'h1;
            end
        end
    end

    // ----------------------------------------
    // parity check and latency stage
    // ----------------------------------------
    reg holdValid_reg;
    reg [`DPT_CMD_W-1:0] holdCmd_reg;
    reg [`DPT_ADDR_W-1:0] holdAddr_reg;
    reg [1:0] dropCnt_reg;
    wire cmdSeen;
    wire parChecking;
    wire parBad;

    // deselect and a high chip select carry no command
    assign cmdSeen = ckRise & cmdPathOn & ~csNowN & (cmdNow != `DPT_CMD_DES);
    // non-persistent mode stops checking until the flag is cleared
    assign parChecking = parEn & (parPersist | ~parErrFlag);
    assign parBad = cmdSeen & parChecking & (^{cmdNow, addrNow, parNow});

    // one-deep hold stage: a command leaves only after the next edge
    // has been checked, since an error there voids it as well

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            holdValid_reg <= 1'b0;
            holdCmd_reg <= {`DPT_CMD_W{1'b0}};
            holdAddr_reg <= {`DPT_ADDR_W{1'b0}};
            dropCnt_reg <= 2'h0;
            cmdValid <= 1'b0;
            cmdCode <= {`DPT_CMD_W{1'b0}};
            cmdAddr <= {`DPT_ADDR_W{1'b0}};
        end else begin
            cmdValid <= 1'b0;
            if (ckRise) begin
                // held command is released only once the next edge proves clean
                if (holdValid_reg && !parBad) begin
                    cmdValid <= 1'b1;
                    cmdCode <= holdCmd_reg;
                    cmdAddr <= holdAddr_reg;
                end
                if (parBad) begin
                    holdValid_reg <= 1'b0;
                    dropCnt_reg <= `DPT_PL_NCK;
                end else if (dropCnt_reg != 2'h0) begin
                    holdValid_reg <= 1'b0;
                    dropCnt_reg <= dropCnt_reg - 2'h1;
                end else begin
                    holdValid_reg <= cmdSeen;
                end
                holdCmd_reg <= cmdNow;
                holdAddr_reg <= addrNow;
            end
        end
    end

    // ----------------------------------------
    // parity error flag
    // ----------------------------------------
    // set wins over a clear in the same cycle, so an error is never lost
    // to a clear that software issued a moment too early
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            parErrFlag <= 1'b0;
        end else if (parBad) begin
            parErrFlag <= 1'b1;
        end else if (parErrClr) begin
            parErrFlag <= 1'b0;
        end
    end

    // ----------------------------------------
    // write crc error capture
    // ----------------------------------------
    reg [7:0] alertCnt_reg;
    reg crcLoad;
    wire alertActive;

    assign alertActive = alertCnt_reg != `DPT_CNT_ZERO;

    // the 13 ns limit is shorter than one clk, so the pulse is not staged:
    // alert falls at the very edge that samples it
    // a crc error never shortens a longer parity alert already running
    always @* begin
        crcLoad = crcErrPulse & (alertCnt_reg < `DPT_CRC_ALERT_NCK);
    end

    // ----------------------------------------
    // alert width counter
    // ----------------------------------------
    // width is counted in device clock edges: a stopped ck freezes the
    // alert, a limitation the controller must keep in mind
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            alertCnt_reg <= `DPT_CNT_ZERO;
        end else if (parBad) begin
            alertCnt_reg <= `DPT_PAR_ALERT_NCK;
        end else if (crcLoad) begin
            alertCnt_reg <= `DPT_CRC_ALERT_NCK;
        end else if (ckRise && alertActive) begin
            alertCnt_reg <= alertCnt_reg - 8'h01;
        end
    end

    // ----------------------------------------
    // alert output
    // ----------------------------------------
    // low the clk after detection, well inside parity latency
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            alertN <= 1'b1;
        end else begin
            alertN <= ~(parBad | crcLoad | alertActive);
        end
    end

endmodule // dpt_cmd_timing
`default_nettype wire

// ==== dpt_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpt_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic ckePin,
    input wire logic crcErrPulse,
    input wire logic cmdValid,
    input wire logic cmdPathOn,
    input wire logic parErrFlag,
    input wire logic alertN
);
    logic [10:0] lowCnt;
    logic [5:0] ckeCnt;
    // cke count saturates so a long power-down never wraps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lowCnt <= 11'h000;
            ckeCnt <= 6'h00;
        end else begin
            lowCnt <= alertN ? 11'h000 : lowCnt + 11'h001;
            ckeCnt <= ckePin ? 6'h00 : ckeCnt + {5'h00, ~&ckeCnt};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_parOn; $rose(parErrFlag) |-> !alertN; endproperty
    property p_parW; $rose(alertN) && parErrFlag |-> lowCnt inside {[11'h1c0:11'h400]}; endproperty
    property p_crcOn; crcErrPulse |-> ##1 !alertN; endproperty
    property p_crcW; $rose(alertN) && !parErrFlag |-> lowCnt inside {[11'h030:11'h050]}; endproperty
    property p_pathOff; $fell(cmdPathOn) |-> ckeCnt inside {[6'h18:6'h28]}; endproperty
    property p_drop; $rose(parErrFlag) |-> !cmdValid [*8]; endproperty
    a_parOn: assert property (p_parOn) else $error("parity alert late");
    a_parW: assert property (p_parW) else $error("parity alert width");
    a_crcOn: assert property (p_crcOn) else $error("crc alert late");
    a_crcW: assert property (p_crcW) else $error("crc alert width");
    a_pathOff: assert property (p_pathOff) else $error("path off timing");
    a_drop: assert property (p_drop) else $error("errant command ran");
    c_par: cover property ($rose(parErrFlag));
    c_crc: cover property (crcErrPulse);
    c_off: cover property ($fell(cmdPathOn));
endmodule // dpt_checker
`default_nettype wire

// ==== dpt_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpt_ctl (
    input wire logic [3:0] nCmd,
    input wire logic [7:0] nAddr,
    input wire logic nCke,
    input wire logic nBad,
    output logic ckPin,
    output logic ckePin,
    output logic csPinN,
    output logic [3:0] cmdPin,
    output logic [7:0] addrPin,
    output logic parPin
);
    initial begin
        {ckePin, csPinN, cmdPin, addrPin, parPin} = 15'h7e00;
        ckPin = 1'b0;
        #7;
        forever #160 ckPin = ~ckPin;
    end
    // launch on falling ck, half a period of margin each side
    always @(negedge ckPin) begin
        ckePin <= nCke;
        csPinN <= &nCmd;
        cmdPin <= nCmd;
        addrPin <= nAddr;
        parPin <= ^{nCmd, nAddr, nBad};
    end
endmodule // dpt_ctl
`default_nettype wire

// ==== dpt_cmd_timing_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpt_cmd_timing_tb_top;
    logic clk, rst, ckPin, ckePin, csPinN, parPin, parEn, parErrClr, crcErrPulse;
    logic nCke, nBad, cmdValid, cmdPathOn, parErrFlag, alertN;
    logic [3:0] cmdPin, cmdCode, nCmd;
    logic [7:0] addrPin, cmdAddr, nAddr;
    int miscompares = 0;
    int checked = 0;
    int validCnt = 0;
    logic parPersist;
    localparam int PdenGap = 12;
    localparam int MrdGap = 16;
    localparam int WlvlGap = 40;
    dpt_ctl ctl (.nCmd(nCmd), .nAddr(nAddr), .nCke(nCke), .nBad(nBad), .ckPin(ckPin),
        .ckePin(ckePin), .csPinN(csPinN), .cmdPin(cmdPin), .addrPin(addrPin), .parPin(parPin));
    dpt_cmd_timing dut (.clk(clk), .rst(rst), .ckPin(ckPin), .ckePin(ckePin), .csPinN(csPinN),
        .cmdPin(cmdPin), .addrPin(addrPin), .parPin(parPin), .parEn(parEn),
        .parPersist(parPersist),
        .parErrClr(parErrClr), .crcErrPulse(crcErrPulse), .cmdValid(cmdValid),
        .cmdCode(cmdCode), .cmdAddr(cmdAddr), .cmdPathOn(cmdPathOn),
        .parErrFlag(parErrFlag), .alertN(alertN));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic ckWait(input int n);
        repeat (n) @(posedge ckPin);
        @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        if (cmdValid)
            validCnt++;
    end
    task automatic issue(input logic [3:0] c, input logic [7:0] a, input logic b);
        {nCmd, nAddr, nBad} = {c, a, b};
        ckWait(1);
        {nCmd, nBad} = 5'h1e;
        clkStep();
    endtask
    task automatic clkStep;
        @(posedge clk);
        #1;
    endtask
    task automatic t_cmd;
        issue(4'h1, 8'h5a, 1'b0);
        issue(4'h2, 8'ha5, 1'b0);
        ckWait(2);
        chk({cmdCode, 4'h0}, 8'h20);
        chk(cmdAddr, 8'ha5);
        chk(validCnt[7:0], 8'h02);
    endtask
    task automatic t_mrs;
        issue(4'h0, 8'h01, 1'b0);
        ckWait(MrdGap);
        issue(4'h0, 8'h02, 1'b0);
        ckWait(WlvlGap);
        chk({cmdCode, 4'h0}, 8'h00);
        chk(cmdAddr, 8'h02);
        chk(validCnt[7:0], 8'h04);
    endtask
    task automatic t_cke;
        ckWait(PdenGap);
        nCke = 1'b0;
        issue(4'h3, 8'h11, 1'b0);
        ckWait(2);
        chk(cmdPathOn, 1'b1);
        ckWait(3);
        chk(cmdPathOn, 1'b0);
        chk(cmdCode, 4'h3);
        nCke = 1'b1;
        ckWait(3);
        chk(cmdPathOn, 1'b1);
        ckWait(1);
        chk(validCnt[7:0], 8'h05);
    endtask
    task automatic t_par;
        parEn = 1'b1;
        issue(4'h4, 8'h22, 1'b1);
        ckWait(3);
        chk({alertN, parErrFlag}, 2'h1);
        chk(cmdCode, 4'h3);
        ckWait(50);
        chk(alertN, 1'b0);
        ckWait(16);
        chk(alertN, 1'b1);
        parErrClr = 1'b1;
        clkStep();
        parErrClr = 1'b0;
        clkStep();
        chk(parErrFlag, 1'b0);
    endtask
    task automatic t_persist;
        parPersist = 1'b1;
        issue(4'h5, 8'h33, 1'b1);
        ckWait(40);
        issue(4'h6, 8'h44, 1'b1);
        ckWait(30);
        chk(alertN, 1'b0);
        ckWait(40);
        chk(alertN, 1'b1);
        chk(validCnt[7:0], 8'h05);
        parErrClr = 1'b1;
        clkStep();
        parErrClr = 1'b0;
        parPersist = 1'b0;
        clkStep();
        chk(parErrFlag, 1'b0);
    endtask
    task automatic t_crc;
        chk(alertN, 1'b1);
        crcErrPulse = 1'b1;
        clkStep();
        crcErrPulse = 1'b0;
        chk(alertN, 1'b0);
        ckWait(5);
        chk(alertN, 1'b0);
        ckWait(6);
        chk(alertN, 1'b1);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst, parEn, parErrClr, crcErrPulse, nCke, nBad, nCmd, nAddr} = 18'h22f00;
        parPersist = 1'b0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        ckWait(2);
        t_cmd();
        t_mrs();
        t_cke();
        t_par();
        t_persist();
        t_crc();
        wrap_up();
    end
    initial begin
        #400000;
        miscompares++;
        wrap_up();
    end
endmodule // dpt_cmd_timing_tb_top
bind dpt_cmd_timing dpt_checker u_chk (.clk(clk), .rst(rst), .ckePin(ckePin),
    .crcErrPulse(crcErrPulse), .cmdValid(cmdValid), .cmdPathOn(cmdPathOn),
    .parErrFlag(parErrFlag), .alertN(alertN));
`default_nettype wire
